// file: src/teq_pkg.sv
package teq_pkg;

	// Channel count and counter geometry
	localparam int          NCH      = 5;
	localparam int          CNT_W    = 16;
	localparam int          ADDR_W   = 8;
	localparam logic [15:0] CNT_MAX  = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE  = 16'h0001;

	// Register byte offsets
	localparam logic [7:0] OFS_START   = 8'h00;
	localparam logic [7:0] OFS_ONESHOT = 8'h04;
	localparam logic [7:0] OFS_DIRCTL  = 8'h08;
	localparam logic [7:0] OFS_TRGSEL  = 8'h0C;
	localparam logic [7:0] OFS_ZCTRL   = 8'h10;
	// Per-channel pages: page in addr[7:5], channel in addr[4:2]
	localparam logic [2:0] PAGE_MODE   = 3'h1;
	localparam logic [2:0] PAGE_COUNT  = 3'h2;

	// Field positions
	localparam int ONESHOT_ZEN_BIT = 7;
	localparam int DIR_TWOPH_LSB   = 5;
	localparam int ZCTRL_RISE_BIT  = 0;

	// Reset values
	localparam logic [4:0] RST_START  = 5'h00;
	localparam logic [4:0] RST_SWUP   = 5'h00;
	localparam logic [2:0] RST_TWOPH  = 3'h0;
	localparam logic [9:0] RST_TRGSEL = 10'h000;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Channel operating mode
	typedef enum logic [1:0] {
		MODE_OFF     = 2'b00,
		MODE_EVENT   = 2'b01,
		MODE_ONESHOT = 2'b10
	} teq_mode_e;

	// Count / trigger source select
	typedef enum logic [1:0] {
		TRG_PIN   = 2'b00,
		TRG_COMP  = 2'b01,
		TRG_LOWER = 2'b10,
		TRG_UPPER = 2'b11
	} teq_trg_e;

	// Channel mode register layout
	typedef struct packed {
		logic      quadX4;
		logic      edgeFall;
		logic      dirByPin;
		logic      freeRun;
		logic      pulseEn;
		teq_mode_e mode;
	} teq_mode_s;

	localparam teq_mode_s RST_MODE = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
		MODE_OFF};

endpackage

// file: src/teq_timer.sv
`timescale 1ns/10ps

module teq_timer
	import teq_pkg::*;
(
	input  wire logic              clk,            // 125 MHz clock
	input  wire logic              rstn,           // Async reset, low
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,   // Write address
	input  wire logic              s_axi_awvalid,  // Write address valid
	output logic                   s_axi_awready,  // Write address ready
	input  wire logic [31:0]       s_axi_wdata,    // Write data
	input  wire logic [3:0]        s_axi_wstrb,    // Write byte strobes
	input  wire logic              s_axi_wvalid,   // Write data valid
	output logic                   s_axi_wready,   // Write data ready
	output logic [1:0]             s_axi_bresp,    // Write response
	output logic                   s_axi_bvalid,   // Write response valid
	input  wire logic              s_axi_bready,   // Write response ready
	input  wire logic [ADDR_W-1:0] s_axi_araddr,   // Read address
	input  wire logic              s_axi_arvalid,  // Read address valid
	output logic                   s_axi_arready,  // Read address ready
	output logic [31:0]            s_axi_rdata,    // Read data
	output logic [1:0]             s_axi_rresp,    // Read response
	output logic                   s_axi_rvalid,   // Read data valid
	input  wire logic              s_axi_rready,   // Read data ready
	input  wire logic              companionOvf,   // Companion timer wrap
	input  wire logic [NCH-1:0]    inPin,          // Timer input pins
	input  wire logic [NCH-1:0]    outPinIn,       // Output pins, level in
	output logic [NCH-1:0]         outPinOut,      // Output pins, drive
	output logic [NCH-1:0]         outPinOe,       // Output pins, enable
	input  wire logic              zPinIn,         // Z-phase input pin
	output logic [NCH-1:0]         irqReq          // Interrupt pulses
);

	// Pin synchronisers, third stage is edge history
	logic [NCH-1:0] inS1, inS2, inS3;
	logic [NCH-1:0] outS1, outS2, outS3;
	logic           zS1, zS2, zS3;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			inS1  <= '0;
			inS2  <= '0;
			inS3  <= '0;
			outS1 <= '0;
			outS2 <= '0;
			outS3 <= '0;
			zS1   <= 1'b0;
			zS2   <= 1'b0;
			zS3   <= 1'b0;
		end
		else
		begin
			inS1  <= inPin;
			inS2  <= inS1;
			inS3  <= inS2;
			outS1 <= outPinIn;
			outS2 <= outS1;
			outS3 <= outS2;
			zS1   <= zPinIn;
			zS2   <= zS1;
			zS3   <= zS2;
		end
	end

	// Software state
	logic [4:0]  startBits, next_startBits;
	logic        zEn, next_zEn;
	logic [4:0]  swUp, next_swUp;
	logic [2:0]  twoPh, next_twoPh;
	logic [9:0]  trgSel, next_trgSel;
	logic        zRise, next_zRise;
	teq_mode_s   modeReg [NCH];
	teq_mode_s   next_modeReg [NCH];
	logic        next_awready, next_bvalid, next_arready, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata;

	// Write decode results, shared with the channels
	logic           wrEn;
	logic [31:0]    wMerged;
	logic [NCH-1:0] wrCnt;
	logic [NCH-1:0] swTrig;

	// Channel state made visible to the bus and the neighbours
	logic [NCH*CNT_W-1:0] cntFlat;
	logic [NCH-1:0]       wrapFlat;
	logic [NCH-1:0]       runFlat;

	// Address map check
	function automatic logic isMapped(input logic [ADDR_W-1:0] a);
		logic chan;
		chan = (a[7:5] == PAGE_MODE || a[7:5] == PAGE_COUNT)
			&& a[4:2] < 3'(NCH) && a[1:0] == 2'b00;
		return chan || a == OFS_START || a == OFS_ONESHOT
			|| a == OFS_DIRCTL || a == OFS_TRGSEL || a == OFS_ZCTRL;
	endfunction

	// Register readback; one-shot count value has no defined meaning
	function automatic logic [31:0] regRead(input logic [ADDR_W-1:0] a);
		logic [31:0] v;
		logic [2:0]  ch;
		v  = '0;
		ch = a[4:2];
		if (a == OFS_START)
			v[4:0] = startBits;
		else if (a == OFS_ONESHOT)
			v[ONESHOT_ZEN_BIT] = zEn;
		else if (a == OFS_DIRCTL)
			v[7:0] = {twoPh, swUp};
		else if (a == OFS_TRGSEL)
			v[9:0] = trgSel;
		else if (a == OFS_ZCTRL)
			v[ZCTRL_RISE_BIT] = zRise;
		else if (isMapped(a) && a[7:5] == PAGE_MODE)
			v[6:0] = modeReg[ch];
		else if (isMapped(a) && a[7:5] == PAGE_COUNT)
			v[15:0] = cntFlat[ch*CNT_W +: CNT_W];
		return v;
	endfunction

	// Bus handshakes and register writes
	always_comb
	begin
		next_startBits = startBits;
		next_zEn       = zEn;
		next_swUp      = swUp;
		next_twoPh     = twoPh;
		next_trgSel    = trgSel;
		next_zRise     = zRise;
		next_modeReg   = modeReg;
		next_bresp     = s_axi_bresp;
		next_rresp     = s_axi_rresp;
		next_rdata     = s_axi_rdata;
		wrCnt          = '0;
		swTrig         = '0;
		wrEn = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
		wMerged = regRead(s_axi_awaddr);
		for (int b = 0; b < 4; b++)
		begin
			if (s_axi_wstrb[b])
				wMerged[b*8 +: 8] = s_axi_wdata[b*8 +: 8];
		end
		// Address and data taken together, one cycle ready pulse
		next_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
			& ~s_axi_bvalid;
		next_bvalid = s_axi_bvalid & ~s_axi_bready;
		if (wrEn)
		begin
			next_bvalid = 1'b1;
			next_bresp  = isMapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
			if (s_axi_awaddr == OFS_START)
				next_startBits = wMerged[4:0];
			else if (s_axi_awaddr == OFS_ONESHOT)
			begin
				next_zEn = wMerged[ONESHOT_ZEN_BIT];
				swTrig   = wMerged[4:0];
			end
			else if (s_axi_awaddr == OFS_DIRCTL)
			begin
				next_swUp  = wMerged[4:0];
				next_twoPh = wMerged[DIR_TWOPH_LSB +: 3];
			end
			else if (s_axi_awaddr == OFS_TRGSEL)
				next_trgSel = wMerged[9:0];
			else if (s_axi_awaddr == OFS_ZCTRL)
				next_zRise = wMerged[ZCTRL_RISE_BIT];
			else if (isMapped(s_axi_awaddr)
				&& s_axi_awaddr[7:5] == PAGE_MODE)
				next_modeReg[s_axi_awaddr[4:2]] = wMerged[6:0];
			else if (isMapped(s_axi_awaddr))
				wrCnt[s_axi_awaddr[4:2]] = 1'b1;
		end
		// Read address taken, data one cycle later
		next_arready = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
		next_rvalid  = s_axi_rvalid & ~s_axi_rready;
		if (s_axi_arready & s_axi_arvalid)
		begin
			next_rvalid = 1'b1;
			next_rdata  = regRead(s_axi_araddr);
			next_rresp  = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// Register the bus side
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			startBits     <= RST_START;
			zEn           <= 1'b0;
			swUp          <= RST_SWUP;
			twoPh         <= RST_TWOPH;
			trgSel        <= RST_TRGSEL;
			zRise         <= 1'b0;
			modeReg       <= '{default: RST_MODE};
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end
		else
		begin
			startBits     <= next_startBits;
			zEn           <= next_zEn;
			swUp          <= next_swUp;
			twoPh         <= next_twoPh;
			trgSel        <= next_trgSel;
			zRise         <= next_zRise;
			modeReg       <= next_modeReg;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_awready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

	// Z-phase edge of the selected polarity
	logic zEdge;
	assign zEdge = zRise ? (zS2 & ~zS3) : (~zS2 & zS3);

	// One counter channel per index
	for (genvar g = 0; g < NCH; g++)
	begin : gChan
		localparam int LO = (g + NCH - 1) % NCH;
		localparam int UP = (g + 1) % NCH;

		logic [15:0] cnt, next_cnt, rld, next_rld;
		logic        first, next_first, run, next_run;
		logic        pinLvl, next_pinLvl, pinOe, next_pinOe;
		logic        irq, next_irq, dbl, next_dbl;
		logic        wrap, next_wrap, zPend, next_zPend;
		logic        inRise, inFall, outRise, outFall, inEdge;
		logic        srcEv, quad, x4, zOk, tick, up, hit;
		teq_mode_s   m;

		assign cntFlat[g*CNT_W +: CNT_W] = cnt;
		assign wrapFlat[g] = wrap;
		assign runFlat[g]  = run;
		assign outPinOut[g] = pinLvl;
		assign outPinOe[g]  = pinOe;
		assign irqReq[g]    = irq;

		// Next state of the channel
		always_comb
		begin
			m       = modeReg[g];
			inRise  = inS2[g] & ~inS3[g];
			inFall  = ~inS2[g] & inS3[g];
			outRise = outS2[g] & ~outS3[g];
			outFall = ~outS2[g] & outS3[g];
			inEdge  = m.edgeFall ? inFall : inRise;
			case (teq_trg_e'(trgSel[2*g +: 2]))
				TRG_PIN:   srcEv = inEdge;
				TRG_COMP:  srcEv = companionOvf;
				TRG_LOWER: srcEv = wrapFlat[LO];
				TRG_UPPER: srcEv = wrapFlat[UP];
				default:   srcEv = 1'b0;
			endcase
			quad = (g >= 2) && twoPh[(g >= 2) ? g - 2 : 0];
			x4   = (g == 4) || (g == 3 && m.quadX4);
			zOk  = (g == 3) && zEn && quad && m.freeRun && x4
				&& m.mode == MODE_EVENT;
			if (quad && x4)
			begin
				tick = inRise | inFall | outRise | outFall;
				up   = (inRise | inFall) ? (inS2[g] == outS2[g])
					: (outS2[g] != inS2[g]);
			end
			else if (quad)
			begin
				tick = (inRise | inFall) & outS2[g];
				up   = inRise;
			end
			else
			begin
				tick = srcEv;
				up   = m.dirByPin ? outS2[g] : swUp[g];
			end
			next_cnt    = cnt;
			next_rld    = rld;
			next_first  = first;
			next_run    = 1'b0;
			next_pinLvl = 1'b0;
			next_irq    = dbl;
			next_dbl    = 1'b0;
			next_wrap   = 1'b0;
			next_zPend  = zOk & (zPend | zEdge);
			next_pinOe  = m.pulseEn && m.mode != MODE_OFF && !quad
				&& !(m.mode == MODE_EVENT && m.dirByPin);
			hit         = 1'b0;
			if (!startBits[g])
				next_first = 1'b0;
			else if (m.mode == MODE_EVENT)
			begin
				next_pinLvl = pinLvl;
				if (tick)
				begin
					next_first = 1'b1;
					if (up && cnt == CNT_MAX)
					begin
						hit = 1'b1;
						next_cnt = m.freeRun ? CNT_ZERO : rld;
					end
					else if (!up && cnt == CNT_ZERO)
					begin
						hit = 1'b1;
						next_cnt = m.freeRun ? CNT_MAX : rld;
						next_pinLvl = pinLvl ^ m.pulseEn;
					end
					else
						next_cnt = up ? cnt + CNT_ONE : cnt - CNT_ONE;
					next_wrap = hit;
					next_irq  = dbl | hit;
					if (zPend)
					begin
						next_cnt   = CNT_ZERO;
						next_zPend = zOk & zEdge;
						next_irq   = 1'b1;
						next_dbl   = hit;
					end
				end
			end
			else if (m.mode == MODE_ONESHOT)
			begin
				if ((srcEv | swTrig[g]) && rld != CNT_ZERO)
				begin
					next_cnt   = rld;
					next_run   = 1'b1;
					next_first = 1'b1;
				end
				else if (run && cnt == CNT_ONE)
				begin
					next_cnt  = rld;
					next_irq  = 1'b1;
					next_wrap = 1'b1;
				end
				else if (run)
				begin
					next_cnt = cnt - CNT_ONE;
					next_run = 1'b1;
				end
				next_pinLvl = next_run & m.pulseEn;
			end
			if (wrCnt[g])
			begin
				next_rld = wMerged[15:0];
				if (!startBits[g] || !first)
					next_cnt = wMerged[15:0];
			end
		end

		// Register the channel
		always_ff @(posedge clk or negedge rstn)
		begin
			if (!rstn)
			begin
				cnt    <= CNT_ZERO;
				rld    <= CNT_ZERO;
				first  <= 1'b0;
				run    <= 1'b0;
				pinLvl <= 1'b0;
				pinOe  <= 1'b0;
				irq    <= 1'b0;
				dbl    <= 1'b0;
				wrap   <= 1'b0;
				zPend  <= 1'b0;
			end
			else
			begin
				cnt    <= next_cnt;
				rld    <= next_rld;
				first  <= next_first;
				run    <= next_run;
				pinLvl <= next_pinLvl;
				pinOe  <= next_pinOe;
				irq    <= next_irq;
				dbl    <= next_dbl;
				wrap   <= next_wrap;
				zPend  <= next_zPend;
			end
		end
	end

endmodule

// file: test/teq_checker.sv
`timescale 1ns/10ps

// Bus handshake and interrupt pulse watcher
module teq_checker
	import teq_pkg::*;
(
	input wire logic           clk,            // Clock
	input wire logic           rstn,           // Reset, low
	input wire logic           s_axi_awvalid,  // Write address valid
	input wire logic           s_axi_awready,  // Write address ready
	input wire logic           s_axi_wvalid,   // Write data valid
	input wire logic           s_axi_wready,   // Write data ready
	input wire logic           s_axi_bvalid,   // Write response valid
	input wire logic           s_axi_bready,   // Write response ready
	input wire logic           s_axi_arvalid,  // Read address valid
	input wire logic           s_axi_arready,  // Read address ready
	input wire logic           s_axi_rvalid,   // Read data valid
	input wire logic           s_axi_rready,   // Read data ready
	input wire logic [NCH-1:0] irqReq          // Interrupt pulses
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// Steps of a write and a read
	sequence wrAsk;
		s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
	endsequence
	sequence wrTaken;
		s_axi_awready && s_axi_awvalid && s_axi_wvalid;
	endsequence
	sequence rdAsk;
		s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
	endsequence

	// Handshake relations and interrupt pulse length
	aw_w_pair_a: assert property (s_axi_awready == s_axi_wready)
		else $error("awready and wready differ");
	aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	wr_resp_a: assert property (wrAsk |=> wrTaken ##1 s_axi_bvalid)
		else $error("write not answered in two cycles");
	b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid kept after handshake");
	ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("arready longer than one cycle");
	rd_resp_a: assert property (rdAsk |=> s_axi_arready ##1 s_axi_rvalid)
		else $error("read not answered in two cycles");
	r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid kept after handshake");
	irq_pulse_a: assert property ((irqReq & 5'h17) != 5'h00 |=>
		(irqReq & $past(irqReq) & 5'h17) == 5'h00)
		else $error("interrupt pulse too long");
endmodule

bind teq_timer teq_checker chk (
	.clk(clk),
	.rstn(rstn),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.irqReq(irqReq)
);

// file: test/teq_pulse_model.sv
`timescale 1ns/10ps

// Pulse source and two-phase encoder on the pins
module teq_pulse_model
	import teq_pkg::*;
(
	input wire logic       clk,   // Clock
	output logic [NCH-1:0] pinA,  // Input pins
	output logic [NCH-1:0] pinB,  // Phase on output pins
	output logic           zPin   // Z-phase pin
);
	initial
	begin
		pinA = '0;
		pinB = '0;
		zPin = 1'b0;
	end

	// Levels held six clocks, past the synchroniser
	task automatic hold();
		repeat (6) @(posedge clk);
	endtask

	// One pulse on an input pin
	task automatic pulse(input int ch);
		@(posedge clk);
		pinA[ch] <= 1'b1;
		hold();
		pinA[ch] <= 1'b0;
		hold();
	endtask

	// One Z-phase pulse, held six clocks, shorter than one seven-clock encoder step
	task automatic zPulse();
		@(posedge clk);
		zPin <= 1'b1;
		hold();
		zPin <= 1'b0;
		hold();
	endtask

	// One encoder cycle, one pin per step; up when B leads
	task automatic quad(input int ch, input logic up);
		for (int s = 0; s < 4; s++)
		begin
			@(posedge clk);
			if (up ^ s[0])
				pinB[ch] <= ~pinB[ch];
			else
				pinA[ch] <= ~pinA[ch];
			hold();
		end
	endtask
endmodule

// file: test/testbench.sv
`timescale 1ns/10ps

// Self-checking bench of the timer block
module testbench
	import teq_pkg::*;
;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  awAddr = 8'h00;
	logic [7:0]  arAddr = 8'h00;
	logic [31:0] wData = 32'h00000000;
	logic        awVal = 1'b0;
	logic        wVal = 1'b0;
	logic        bRdy = 1'b0;
	logic        arVal = 1'b0;
	logic        rRdy = 1'b0;
	logic        compOvf = 1'b0;
	logic        zPin;
	logic        awRdy, wRdy, bVal, arRdy, rVal;
	logic [1:0]  bResp, rResp;
	logic [31:0] rData;
	logic [31:0] lfsr = 32'hF5EA7171;
	logic [15:0] n;
	logic [4:0]  inPin, phB, outOut, outOe, irq, outIn;
	logic [33:0] expQ[$];
	int          irqCnt[NCH] = '{default: 0};
	int          highCnt = 0;
	int          h0;
	int          tGap;
	int          cyc = 0;
	int          failures = 0;
	int          checked = 0;

	always #4 clk = ~clk;

	// Output pins read back what the device drives, else the encoder
	assign outIn = (outOe & outOut) | (~outOe & phB);

	teq_timer uut (
		.clk(clk), .rstn(rstn),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awVal),
		.s_axi_awready(awRdy), .s_axi_wdata(wData),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wVal), .s_axi_wready(wRdy),
		.s_axi_bresp(bResp), .s_axi_bvalid(bVal), .s_axi_bready(bRdy),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arVal),
		.s_axi_arready(arRdy), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rVal), .s_axi_rready(rRdy),
		.companionOvf(compOvf), .inPin(inPin), .outPinIn(outIn),
		.outPinOut(outOut), .outPinOe(outOe), .zPinIn(zPin),
		.irqReq(irq)
	);

	teq_pulse_model src (
		.clk(clk),
		.pinA(inPin),
		.pinB(phB),
		.zPin(zPin)
	);

	function automatic logic [31:0] lfsrNext(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic check(input string nm, input logic [33:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// AXI4-Lite write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awAddr <= a;
		wData <= d;
		awVal <= 1'b1;
		wVal <= 1'b1;
		bRdy <= 1'b1;
		do @(posedge clk); while (awRdy !== 1'b1);
		awVal <= 1'b0;
		wVal <= 1'b0;
		while (bVal !== 1'b1) @(posedge clk);
		bRdy <= 1'b0;
	endtask

	// AXI4-Lite read, expected response and data noted first
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		expQ.push_back(e);
		@(posedge clk);
		arAddr <= a;
		arVal <= 1'b1;
		rRdy <= 1'b1;
		do @(posedge clk); while (arRdy !== 1'b1);
		arVal <= 1'b0;
		while (rVal !== 1'b1) @(posedge clk);
		rRdy <= 1'b0;
	endtask

	// One companion wrap pulse
	task automatic tick();
		@(posedge clk);
		compOvf <= 1'b1;
		@(posedge clk);
		compOvf <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// Read results, interrupt and pulse counts, timeout
	always @(posedge clk)
	begin
		if (rVal === 1'b1 && rRdy === 1'b1)
			check("read", {rResp, rData}, expQ.pop_front());
		for (int i = 0; i < NCH; i++)
			irqCnt[i] += (irq[i] === 1'b1);
		highCnt += (outOut[2] === 1'b1);
		cyc++;
		if (cyc == 30000)
		begin
			failures++;
			stop_test();
		end
	end

	// Main sequence
	initial
	begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		wr(8'h20, 32'h5);
		wr(8'h40, 32'h2);
		wr(8'h00, 32'h1);
		rd(8'h40, 34'h2);
		repeat (2) src.pulse(0);
		rd(8'h40, 34'h0);
		src.pulse(0);
		rd(8'h40, 34'h2);
		check("irq0", irqCnt[0], 1);
		check("pin0", outOut[0], 1);
		wr(8'h40, 32'h5);
		rd(8'h40, 34'h2);
		wr(8'h00, 32'h0);
		repeat (3) @(negedge clk);
		check("pin0 idle", outOut[0], 0);
		src.pulse(0);
		rd(8'h40, 34'h2);
		wr(8'h24, 32'h9);
		wr(8'h0C, 32'h7);
		wr(8'h08, 32'h2);
		wr(8'h44, 32'hFFFE);
		wr(8'h00, 32'h3);
		repeat (2) tick();
		rd(8'h44, 34'h0);
		rd(8'h40, 34'h1);
		check("irq1", irqCnt[1], 1);
		tick();
		rd(8'h44, 34'h1);
		wr(8'h08, 32'h82);
		wr(8'h30, 32'h1);
		wr(8'h50, 32'h10);
		wr(8'h00, 32'h12);
		src.quad(4, 1'b1);
		rd(8'h50, 34'h14);
		repeat (2) src.quad(4, 1'b0);
		rd(8'h50, 34'h0C);
		lfsr = lfsrNext(lfsr);
		n = {13'h0, lfsr[2:0]} + 16'h2;
		wr(8'h28, 32'h6);
		wr(8'h48, {16'h0, n});
		wr(8'h00, 32'h16);
		h0 = highCnt;
		wr(8'h04, 32'h4);
		repeat (n + 6) @(negedge clk);
		check("high", highCnt - h0, n);
		check("irq2", irqCnt[2], 1);
		wr(8'h48, 32'h10);
		h0 = highCnt;
		wr(8'h04, 32'h4);
		tGap = int'($time);
		wr(8'h04, 32'h4);
		tGap = (int'($time) - tGap) / 8;
		repeat (24) @(negedge clk);
		check("retrig high", highCnt - h0, tGap + 16);
		check("retrig irq", irqCnt[2], 2);
		wr(8'h48, 32'h0);
		h0 = highCnt;
		wr(8'h04, 32'h4);
		repeat (8) @(negedge clk);
		check("zero high", highCnt - h0, 0);
		check("zero irq", irqCnt[2], 2);
		wr(8'h00, 32'h0);
		wr(8'h08, 32'hE2);
		wr(8'h28, 32'h1);
		wr(8'h2C, 32'h49);
		wr(8'h48, 32'h20);
		wr(8'h4C, 32'h0);
		wr(8'h04, 32'h80);
		wr(8'h10, 32'h1);
		wr(8'h00, 32'h0C);
		repeat (2) src.quad(2, 1'b1);
		src.quad(2, 1'b0);
		rd(8'h48, 34'h21);
		src.zPulse();
		src.quad(3, 1'b1);
		rd(8'h4C, 34'h3);
		check("irq3 z", irqCnt[3], 1);
		src.quad(3, 1'b0);
		check("irq3 wrap", irqCnt[3], 2);
		src.zPulse();
		src.quad(3, 1'b1);
		rd(8'h4C, 34'h3);
		check("irq3 twice", irqCnt[3], 4);
		rd(8'h1C, {RESP_SLVERR, 32'h0});
		stop_test();
	end
endmodule
